// File: hw/baseline_instruction_decoder.sv
// Instruction decoder and executor for a small 8-bit core, Wishbone slave
// Function
// - Add W to file updates carry, digit carry and zero.
// - Destination bit 0 writes W, 1 writes the file register.
// - OR, AND, XOR of W with file change only zero.
// - Decrement or increment and skip when result is zero; flags untouched.
// - Rotates go through carry and change only carry.
// - Bit clear and bit set force one bit, no flags.
// - Bit tests skip on clear or set, no flags.
// - Literal AND, OR, XOR into W change only zero.
// - Return loads literal and pops in two cycles; move literal one cycle.
// - Counter writes clear bit 8 except branch, which loads 9 bits, and return, which loads the stacked address.
// - Fixed words: standby, watchdog clear, option load; timeout and powerdown flags.
// - Direction load for port 6 copies W; a one disables the driver.
// - Port read-modify-write uses the sampled pin levels.
// - Marked writes to the timer clear the prescaler when assigned there.
// - One instruction cycle is four clocks; taken tests and jumps take two.
// - A taken skip executes a no-operation in the second cycle.
// - Call pushes next address, loads literal, page bits, clears bit 8.
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps

module baseline_instruction_decoder
  import decoder_pkg::*;
#(
  parameter logic [10:0] PC_RESET = PC_RST
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Wishbone slave
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK,
  // Port pins
  input  wire logic [7:0]  IO_PIN_IN,
  output logic      [7:0]  IO_PIN_OUT,
  output logic      [7:0]  IO_PIN_OE,
  // Side effects towards timer, watchdog and power logic
  output logic             STANDBY_REQ,
  output logic             WDT_CLEAR,
  output logic             PRESCALER_CLEAR,
  output logic      [7:0]  OPTION_Q,
  output logic             BUSY
);

  core_state_type s_r;
  core_state_type s_nxt;

  logic        exec_now;
  logic        bus_req;
  logic [4:0]  f;
  logic        d;
  logic [2:0]  b;
  logic [7:0]  k;
  logic [7:0]  src;
  logic [7:0]  res;
  logic [8:0]  sum9;
  logic [8:0]  dif9;
  logic [4:0]  nib5;
  logic        wr_w;
  logic        wr_f;
  logic        to_dest;
  logic        marked;
  logic        skip;
  logic        jump;
  logic        z_upd;
  logic        c_upd;
  logic        dc_upd;
  logic        c_val;
  logic        dc_val;
  logic [10:0] tgt;

  // Port reads return synchronised pins, low counter byte for its alias
  function automatic logic [7:0] file_value(input core_state_type s,
                                            input logic [4:0] a);
    if (a == FA_PORT) return s.pin_sync;
    if (a == FA_PCL) return s.pc[7:0];
    return s.file[a];
  endfunction

  assign exec_now = (s_r.st == ST_EXEC) && (s_r.phase == PHASE_LAST);
  assign bus_req  = WB_CYC && WB_STB && !s_r.ack;
  assign f        = s_r.ins[4:0];
  assign d        = s_r.ins[5];
  assign b        = s_r.ins[7:5];
  assign k        = s_r.ins[7:0];
  assign src      = file_value(s_r, f);
  assign sum9     = {1'b0, s_r.work} + {1'b0, src};
  assign dif9     = {1'b0, src} - {1'b0, s_r.work};
  assign nib5     = {1'b0, s_r.work[3:0]} + {1'b0, src[3:0]};

  ////////////////////////////////////////////////////////////////////////
  // Decode of the held instruction
  always_comb begin
    res     = src;
    to_dest = 1'b0;
    wr_w    = 1'b0;
    wr_f    = 1'b0;
    marked  = 1'b0;
    skip    = 1'b0;
    jump    = 1'b0;
    z_upd   = 1'b0;
    c_upd   = 1'b0;
    dc_upd  = 1'b0;
    c_val   = s_r.file[FA_STATUS][SB_C];
    dc_val  = 1'b0;
    tgt     = 11'(s_r.pc + 11'h001);
    unique case (s_r.ins[11:8])
      4'h0, 4'h1, 4'h2, 4'h3: begin
        unique case (s_r.ins[9:6])
          CL_MISC: begin
            res    = s_r.work;
            wr_f   = d;
            marked = d;
          end
          CL_CLR: begin
            res    = 8'h00;
            z_upd  = d || (f == 5'h00);
            wr_f   = d;
            wr_w   = !d && (f == 5'h00);
            marked = d;
          end
          CL_SUB: begin
            res     = dif9[7:0];
            c_val   = !dif9[8];
            dc_val  = src[3:0] >= s_r.work[3:0];
            {z_upd, c_upd, dc_upd} = 3'h7;
            to_dest = 1'b1;
          end
          CL_ADD: begin
            res     = sum9[7:0];
            c_val   = sum9[8];
            dc_val  = nib5[4];
            {z_upd, c_upd, dc_upd} = 3'h7;
            to_dest = 1'b1;
          end
          CL_OR, CL_AND, CL_XOR: begin
            res     = (s_r.ins[9:6] == CL_OR)  ? (s_r.work | src) :
                      (s_r.ins[9:6] == CL_AND) ? (s_r.work & src) :
                                                 (s_r.work ^ src);
            z_upd   = 1'b1;
            to_dest = 1'b1;
          end
          CL_DEC, CL_INC, CL_MOV, CL_COM: begin
            res     = (s_r.ins[9:6] == CL_DEC) ? 8'(src - 8'h01) :
                      (s_r.ins[9:6] == CL_INC) ? 8'(src + 8'h01) :
                      (s_r.ins[9:6] == CL_COM) ? ~src : src;
            z_upd   = 1'b1;
            to_dest = 1'b1;
          end
          CL_DECS, CL_INCS: begin
            res     = (s_r.ins[9:6] == CL_DECS) ? 8'(src - 8'h01)
                                                : 8'(src + 8'h01);
            skip    = (res == 8'h00);
            to_dest = 1'b1;
          end
          CL_RRC, CL_RLC: begin
            res     = (s_r.ins[9:6] == CL_RRC) ? {c_val, src[7:1]}
                                               : {src[6:0], c_val};
            c_val   = (s_r.ins[9:6] == CL_RRC) ? src[0] : src[7];
            c_upd   = 1'b1;
            to_dest = 1'b1;
          end
          CL_SWAP: begin
            res     = {src[3:0], src[7:4]};
            to_dest = 1'b1;
          end
        endcase
        if (to_dest) begin
          wr_f   = d;
          wr_w   = !d;
          marked = (s_r.ins[9:6] != CL_COM);
        end
      end
      OP_BIT_CLEAR, OP_BIT_SET: begin
        res       = src;
        res[b]    = s_r.ins[8];
        wr_f      = 1'b1;
        marked    = 1'b1;
      end
      OP_TEST_CLR, OP_TEST_SET: begin
        skip = (src[b] == s_r.ins[8]);
      end
      OP_RET_LIT: begin
        res  = k;
        wr_w = 1'b1;
        jump = 1'b1;
        tgt  = s_r.stack0;
      end
      OP_CALL: begin
        jump = 1'b1;
        tgt  = {s_r.file[FA_STATUS][6:5], 1'b0, k};
      end
      OP_BRANCH_LO, OP_BRANCH_HI: begin
        jump = 1'b1;
        tgt  = {s_r.file[FA_STATUS][6:5], s_r.ins[8:0]};
      end
      OP_MOVE_LIT: begin
        res  = k;
        wr_w = 1'b1;
      end
      OP_OR_LIT, OP_AND_LIT, OP_XOR_LIT: begin
        res   = (s_r.ins[11:8] == OP_OR_LIT)  ? (s_r.work | k) :
                (s_r.ins[11:8] == OP_AND_LIT) ? (s_r.work & k) :
                                                (s_r.work ^ k);
        wr_w  = 1'b1;
        z_upd = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: pin sampling, bus slave, sequencing and execution
  always_comb begin
    s_nxt          = s_r;
    s_nxt.pin_meta = IO_PIN_IN;
    s_nxt.pin_sync = s_r.pin_meta;
    s_nxt.ack      = 1'b0;
    s_nxt.standby  = 1'b0;
    s_nxt.wdt      = 1'b0;
    s_nxt.presc    = 1'b0;
    // Writes stall while busy so software never races the executor
    if (bus_req && (!WB_WE || s_r.st == ST_IDLE)) begin
      s_nxt.ack = 1'b1;
      unique case (WB_ADR)
        OFS_INSTR:  s_nxt.dat = {20'h00000, s_r.ins};
        OFS_WORK:   s_nxt.dat = {24'h000000, s_r.work};
        OFS_PC:     s_nxt.dat = {21'h000000, s_r.pc};
        OFS_DIR:    s_nxt.dat = {24'h000000, s_r.dir};
        OFS_OPTION: s_nxt.dat = {24'h000000, s_r.option};
        OFS_EVENTS: s_nxt.dat = {29'h00000000, s_r.events};
        OFS_BUSY:   s_nxt.dat = {31'h00000000, s_r.st != ST_IDLE};
        default:    s_nxt.dat = (WB_ADR[OFS_FILE_BIT] && WB_ADR[1:0] == 2'h0)
                      ? {24'h000000, file_value(s_r, WB_ADR[6:2])} : 32'h00000000;
      endcase
      if (WB_WE) begin
        if (WB_ADR == OFS_INSTR && WB_SEL[1:0] == 2'h3) begin
          s_nxt.ins   = WB_DAT_I[11:0];
          s_nxt.st    = ST_EXEC;
          s_nxt.phase = 2'h0;
        end
        if (WB_ADR == OFS_WORK && WB_SEL[0]) s_nxt.work = WB_DAT_I[7:0];
        if (WB_ADR == OFS_PC && WB_SEL[1:0] == 2'h3) s_nxt.pc = WB_DAT_I[10:0];
        if (WB_ADR == OFS_EVENTS && WB_SEL[0]) begin
          s_nxt.events = s_r.events & ~WB_DAT_I[2:0];
        end
        if (WB_ADR[OFS_FILE_BIT] && WB_ADR[1:0] == 2'h0 && WB_SEL[0]) begin
          s_nxt.file[WB_ADR[6:2]] = WB_DAT_I[7:0];
        end
      end
    end
    // Four-clock instruction cycle, phase counter acts as the divider
    if (s_r.st != ST_IDLE) begin
      s_nxt.phase = 2'(s_r.phase + 2'h1);
      if (s_r.phase == PHASE_LAST && s_r.st == ST_SECOND) begin
        s_nxt.st = ST_IDLE;
      end
    end
    if (exec_now) begin
      if (wr_w) s_nxt.work = res;
      if (wr_f) begin
        // Low counter byte is no file cell; the counter update below takes it
        if (f == FA_STATUS) begin
          s_nxt.file[FA_STATUS] = (res & ~STATUS_KEEP)
                                | (s_r.file[FA_STATUS] & STATUS_KEEP);
        end else if (f != FA_PCL) begin
          s_nxt.file[f] = res;
        end
      end
      // Flag updates override a status destination write
      if (z_upd) s_nxt.file[FA_STATUS][SB_Z] = (res == 8'h00);
      if (c_upd) s_nxt.file[FA_STATUS][SB_C] = c_val;
      if (dc_upd) s_nxt.file[FA_STATUS][SB_DC] = dc_val;
      if (marked && wr_f && f == FA_TIMER && !s_r.option[OPT_PSA]) begin
        s_nxt.presc            = 1'b1;
        s_nxt.events[EV_PRESC] = 1'b1;
      end
      if (s_r.ins[11:5] == 7'h00) begin
        unique case (f)
          FW_OPTION: s_nxt.option = s_r.work;
          FW_STANDBY: begin
            s_nxt.file[FA_STATUS][SB_TO] = 1'b1;
            s_nxt.file[FA_STATUS][SB_PD] = 1'b0;
            s_nxt.standby                = 1'b1;
            s_nxt.events[EV_STANDBY]     = 1'b1;
          end
          FW_WDT: begin
            s_nxt.file[FA_STATUS][SB_TO] = 1'b1;
            s_nxt.file[FA_STATUS][SB_PD] = 1'b1;
            s_nxt.wdt                    = 1'b1;
            s_nxt.events[EV_WDT]         = 1'b1;
          end
          FW_DIR: s_nxt.dir = s_r.work;
          default: ;
        endcase
      end
      if (s_r.ins[11:8] == OP_CALL) begin
        s_nxt.stack1 = s_r.stack0;
        s_nxt.stack0 = 11'(s_r.pc + 11'h001);
      end
      if (s_r.ins[11:8] == OP_RET_LIT) s_nxt.stack0 = s_r.stack1;
      // Low byte write to the counter clears bit 8
      if (wr_f && f == FA_PCL) begin
        s_nxt.pc = {s_r.file[FA_STATUS][6:5], 1'b0, res};
      end else if (jump) begin
        s_nxt.pc = tgt;
      end else begin
        s_nxt.pc = 11'(s_r.pc + (skip ? 11'h002 : 11'h001));
      end
      s_nxt.st = (skip || jump || (wr_f && f == FA_PCL)) ? ST_SECOND : ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_r                 <= '0;
      s_r.pc              <= PC_RESET;
      s_r.option          <= OPTION_RST;
      s_r.dir             <= DIR_RST;
      s_r.file[FA_STATUS] <= STATUS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign WB_DAT_O        = s_r.dat;
  assign WB_ACK          = s_r.ack;
  assign IO_PIN_OUT      = s_r.file[FA_PORT];
  assign IO_PIN_OE       = ~s_r.dir;
  assign STANDBY_REQ     = s_r.standby;
  assign WDT_CLEAR       = s_r.wdt;
  assign PRESCALER_CLEAR = s_r.presc;
  assign OPTION_Q        = s_r.option;
  assign BUSY            = s_r.st != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_skip_second: assert property (exec_now && skip |=> s_r.st == ST_SECOND)
    else $error("taken skip did not add a second cycle");
  a_single_end: assert property (exec_now && !skip && !jump && !(wr_f && f == FA_PCL)
    |=> s_r.st == ST_IDLE)
    else $error("plain instruction not done in one cycle");
  a_busy_span: assert property ($rose(BUSY) |-> BUSY[*4])
    else $error("instruction cycle shorter than four clocks");
  a_add_carry: assert property (exec_now && s_r.ins[11:6] == {2'h0, CL_ADD}
    |=> s_r.file[FA_STATUS][SB_C] == $past(sum9[8]))
    else $error("add carry wrong");
  a_or_literal: assert property (exec_now && s_r.ins[11:8] == OP_OR_LIT
    |=> s_r.work == ($past(s_r.work) | $past(s_r.ins[7:0])))
    else $error("literal or result wrong");
  a_move_literal: assert property (exec_now && s_r.ins[11:8] == OP_MOVE_LIT
    |=> s_r.work == $past(s_r.ins[7:0])
        && s_r.file[FA_STATUS] == $past(s_r.file[FA_STATUS]))
    else $error("move literal wrong or flags changed");
  a_branch_target: assert property (exec_now && s_r.ins[11:9] == 3'h5
    |=> s_r.pc == {$past(s_r.file[FA_STATUS][6:5]), $past(s_r.ins[8:0])})
    else $error("branch target wrong");
  a_call_push: assert property (exec_now && s_r.ins[11:8] == OP_CALL
    |=> !s_r.pc[8] && s_r.stack0 == 11'($past(s_r.pc) + 11'h001))
    else $error("call push or bit 8 wrong");
  a_dir_copy: assert property (exec_now && s_r.ins == {7'h00, FW_DIR}
    |=> s_r.dir == $past(s_r.work) && IO_PIN_OE == ~$past(s_r.work))
    else $error("direction load wrong");
  a_standby_flags: assert property (exec_now && s_r.ins == {7'h00, FW_STANDBY}
    |=> s_r.file[FA_STATUS][SB_TO] && !s_r.file[FA_STATUS][SB_PD]
        && STANDBY_REQ)
    else $error("standby flags wrong");
  a_bit_set: assert property (exec_now && s_r.ins[11:8] == OP_BIT_SET && f > FA_PORT
    |=> s_r.file[$past(f)][$past(b)]
        && s_r.file[FA_STATUS] == $past(s_r.file[FA_STATUS]))
    else $error("bit set wrong or flags changed");

endmodule // baseline_instruction_decoder

// File: common/decoder_pkg.sv
// Shared constants and types for the baseline instruction decoder
package decoder_pkg;

  // Timing: oscillator periods per instruction cycle, last phase index
  localparam int         QUARTERS   = 4;
  localparam logic [1:0] PHASE_LAST = 2'(QUARTERS - 1);

  // Wishbone byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_WORK   = 8'h04;
  localparam logic [7:0] OFS_PC     = 8'h08;
  localparam logic [7:0] OFS_DIR    = 8'h0c;
  localparam logic [7:0] OFS_OPTION = 8'h10;
  localparam logic [7:0] OFS_EVENTS = 8'h14;
  localparam logic [7:0] OFS_BUSY   = 8'h18;
  localparam int         OFS_FILE_BIT = 7;

  // File register map
  localparam int         FILE_COUNT = 32;
  localparam logic [4:0] FA_TIMER   = 5'h01;
  localparam logic [4:0] FA_PCL     = 5'h02;
  localparam logic [4:0] FA_STATUS  = 5'h03;
  localparam logic [4:0] FA_PORT    = 5'h06;

  // Status bit positions and reset values
  localparam int         SB_C  = 0;
  localparam int         SB_DC = 1;
  localparam int         SB_Z  = 2;
  localparam int         SB_PD = 3;
  localparam int         SB_TO = 4;
  localparam logic [7:0] STATUS_KEEP = 8'h18;
  localparam logic [7:0] STATUS_RST  = 8'h18;
  localparam logic [7:0] OPTION_RST  = 8'hff;
  localparam logic [7:0] DIR_RST     = 8'hff;
  localparam logic [10:0] PC_RST     = 11'h000;
  localparam int         OPT_PSA     = 3;

  // Event bits
  localparam int EV_STANDBY = 0;
  localparam int EV_WDT     = 1;
  localparam int EV_PRESC   = 2;

  // Upper nibble groups
  localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OP_BIT_SET   = 4'h5;
  localparam logic [3:0] OP_TEST_CLR  = 4'h6;
  localparam logic [3:0] OP_TEST_SET  = 4'h7;
  localparam logic [3:0] OP_RET_LIT   = 4'h8;
  localparam logic [3:0] OP_CALL      = 4'h9;
  localparam logic [3:0] OP_BRANCH_LO = 4'ha;
  localparam logic [3:0] OP_BRANCH_HI = 4'hb;
  localparam logic [3:0] OP_MOVE_LIT  = 4'hc;
  localparam logic [3:0] OP_OR_LIT    = 4'hd;
  localparam logic [3:0] OP_AND_LIT   = 4'he;
  localparam logic [3:0] OP_XOR_LIT   = 4'hf;

  // Byte operation classes, instruction bits 9:6 when bits 11:10 are zero
  localparam logic [3:0] CL_MISC = 4'h0;
  localparam logic [3:0] CL_CLR  = 4'h1;
  localparam logic [3:0] CL_SUB  = 4'h2;
  localparam logic [3:0] CL_DEC  = 4'h3;
  localparam logic [3:0] CL_OR   = 4'h4;
  localparam logic [3:0] CL_AND  = 4'h5;
  localparam logic [3:0] CL_XOR  = 4'h6;
  localparam logic [3:0] CL_ADD  = 4'h7;
  localparam logic [3:0] CL_MOV  = 4'h8;
  localparam logic [3:0] CL_COM  = 4'h9;
  localparam logic [3:0] CL_INC  = 4'ha;
  localparam logic [3:0] CL_DECS = 4'hb;
  localparam logic [3:0] CL_RRC  = 4'hc;
  localparam logic [3:0] CL_RLC  = 4'hd;
  localparam logic [3:0] CL_SWAP = 4'he;
  localparam logic [3:0] CL_INCS = 4'hf;

  // Fixed words, low five bits with all upper bits zero
  localparam logic [4:0] FW_OPTION  = 5'h02;
  localparam logic [4:0] FW_STANDBY = 5'h03;
  localparam logic [4:0] FW_WDT     = 5'h04;
  localparam logic [4:0] FW_DIR     = 5'h06;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_EXEC   = 2'h1,
    ST_SECOND = 2'h3
  } exec_state_type;

  typedef struct packed {
    exec_state_type            st;
    logic [1:0]                phase;
    logic [11:0]               ins;
    logic [7:0]                work;
    logic [10:0]               pc;
    logic [10:0]               stack0;
    logic [10:0]               stack1;
    logic [FILE_COUNT-1:0][7:0] file;
    logic [7:0]                dir;
    logic [7:0]                option;
    logic [2:0]                events;
    logic                      ack;
    logic [31:0]               dat;
    logic [7:0]                pin_meta;
    logic [7:0]                pin_sync;
    logic                      standby;
    logic                      wdt;
    logic                      presc;
  } core_state_type;

endpackage

// File: bench/tb_top.sv
// Self-checking testbench for the baseline instruction decoder
`timescale 1ns/1ps

module tb_top
  import decoder_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus, response and model state
  logic        clock, rst, cyc, stb, we, ack, stdby, wdt, presc, busy, d;
  logic [3:0]  sel;
  logic [2:0]  pul_m;
  logic [4:0]  fi;
  logic [7:0]  adr, pin_in, pin_out, pin_oe, opt_q, w_m, v, k, s, dir_m, out_m, opt_m;
  logic [15:0] r;
  logic [31:0] dat_i, dat_o;
  logic [31:0] exp_q[$];
  int          len_q[$];
  int          fail_count, check_count, blen;
  logic [10:0] pc_m;
  logic [3:0]  ops[13] = '{CL_ADD, CL_SUB, CL_OR, CL_AND, CL_XOR, CL_CLR, CL_MOV, CL_COM,
                           CL_INC, CL_DEC, CL_RRC, CL_RLC, CL_SWAP};
  logic [3:0]  lits[4] = '{OP_MOVE_LIT, OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT};
  logic [11:0] nops[5] = '{12'h000, 12'h001, 12'h005, 12'h007, 12'h045};

  baseline_instruction_decoder uut (
    .CLOCK(clock), .RST(rst), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
    .WB_SEL(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK(ack), .IO_PIN_IN(pin_in),
    .IO_PIN_OUT(pin_out), .IO_PIN_OE(pin_oe), .STANDBY_REQ(stdby), .WDT_CLEAR(wdt),
    .PRESCALER_CLEAR(presc), .OPTION_Q(opt_q), .BUSY(busy));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reporting and comparison
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bad(input string m);
    fail_count++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task automatic hang(input string m);
    bad(m);
    complete_run();
  endtask
  task automatic chk_dat(input logic [31:0] got);
    logic [31:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
    check_count++;
    if (got !== e) bad($sformatf("read %h expected %h", got, e));
  endtask
  task automatic chk_len(input int got);
    int e;
    e = (len_q.size() != 0) ? len_q.pop_front() : -1;
    check_count++;
    if (got != e) bad($sformatf("busy %0d cycles expected %0d", got, e));
  endtask
  task automatic chk_lvl(input logic [26:0] got, input logic [26:0] e);
    check_count++;
    if (got !== e) bad($sformatf("pins/option %h expected %h", got, e));
  endtask

  // Reference for byte operations; returns new status and result
  function automatic logic [15:0] ref_op(input logic [3:0] cl, input logic [7:0] w, f, st);
    logic [8:0] sum;
    logic [7:0] n, t;
    logic       z;
    sum = {1'b0, w} + {1'b0, f};
    n = f;
    t = st;
    z = 1'b1;
    case (cl)
      CL_ADD: begin
        n = sum[7:0];
        t[SB_C] = sum[8];
        t[SB_DC] = (w[3:0] + f[3:0]) > 5'd15;
      end
      CL_SUB: begin
        n = f - w;
        t[SB_C] = f >= w;
        t[SB_DC] = f[3:0] >= w[3:0];
      end
      CL_OR:  n = f | w;
      CL_AND: n = f & w;
      CL_XOR: n = f ^ w;
      CL_CLR: n = 8'h00;
      CL_COM: n = ~f;
      CL_INC: n = f + 8'h01;
      CL_DEC: n = f - 8'h01;
      CL_RRC: begin
        n = {st[SB_C], f[7:1]};
        t[SB_C] = f[0];
        z = 1'b0;
      end
      CL_RLC: begin
        n = {f[6:0], st[SB_C]};
        t[SB_C] = f[7];
        z = 1'b0;
      end
      CL_SWAP: begin
        n = {f[3:0], f[7:4]};
        z = 1'b0;
      end
      default: ;
    endcase
    if (z) t[SB_Z] = (n == 8'h00);
    return {t, n};
  endfunction

  function automatic logic [7:0] fa(input logic [4:0] f);
    return {1'b1, f, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone master; request held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] dd);
    int n;
    n = 0;
    {cyc, stb, we, adr, dat_i} <= {2'b11, w, a, dd};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) hang("no acknowledge");
    {cyc, stb, we} <= 3'b000;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    wb(a, 1'b1, dd);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(a, 1'b0, 32'h0);
  endtask
  // Issue one instruction; extra edge lets the monitor retire before models move
  task automatic exec(input logic [11:0] ins, input int c);
    int n;
    n = 0;
    len_q.push_back(c);
    wr(OFS_INSTR, 32'(ins));
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20) hang("busy stuck");
    @(posedge clock);
    pc_m = pc_m + 11'(c / 4);
  endtask

  // Watch outputs and retire the oldest expectation of each kind
  always @(posedge clock) begin
    if (busy === 1'b1) blen++;
    else if (blen != 0) begin
      chk_len(blen);
      chk_lvl({pin_oe, pin_out, opt_q, stdby, wdt, presc},
              {~dir_m, out_m, opt_m, pul_m});
      blen = 0;
    end
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) chk_dat(dat_o);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, cyc, stb, we, sel} = 8'h8f;
    {adr, dat_i, fail_count, check_count, blen} = '0;
    void'($urandom(32'h48d8));
    pin_in = 8'($urandom);
    {dir_m, out_m, opt_m, pc_m} = {DIR_RST, 8'h00, OPTION_RST, PC_RST};
    pul_m = 3'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(fa(FA_STATUS), 32'(STATUS_RST));
    rd(OFS_DIR, 32'(DIR_RST));
    rd(8'h1c, 32'h0);
    // Byte operations, random operands, both destinations
    repeat (3) foreach (ops[i]) begin
      fi = 5'(8 + $urandom % 24);
      {w_m, v, s} = {8'($urandom), 8'($urandom), 5'h03, 3'($urandom)};
      d = (ops[i] == CL_CLR) | 1'($urandom);
      r = ref_op(ops[i], w_m, v, s);
      wr(OFS_WORK, 32'(w_m));
      wr(fa(fi), 32'(v));
      wr(fa(FA_STATUS), 32'(s));
      exec({2'b00, ops[i], d, fi}, 4);
      rd(OFS_WORK, 32'(d ? w_m : r[7:0]));
      rd(fa(fi), 32'(d ? r[7:0] : v));
      rd(fa(FA_STATUS), 32'(r[15:8]));
      rd(OFS_PC, 32'(pc_m));
    end
    // Counting skips around zero; flags must stay put
    wr(fa(FA_STATUS), 32'h1f);
    wr(fa(5'h11), 32'h01);
    exec({2'b00, CL_DECS, 1'b1, 5'h11}, 8);
    exec({2'b00, CL_DECS, 1'b1, 5'h11}, 4);
    exec({2'b00, CL_INCS, 1'b0, 5'h11}, 8);
    rd(fa(5'h11), 32'hff);
    rd(OFS_WORK, 32'h0);
    // Bit tests, set and clear on every bit position
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(fa(5'h10), 32'(v));
      exec({OP_TEST_CLR, 3'(i), 5'h10}, v[i] ? 4 : 8);
      exec({OP_TEST_SET, 3'(i), 5'h10}, v[i] ? 8 : 4);
      exec({OP_BIT_SET, 3'(i), 5'h10}, 4);
      exec({OP_BIT_CLEAR, 3'(7 - i), 5'h10}, 4);
      v[i] = 1'b1;
      v[7 - i] = 1'b0;
      rd(fa(5'h10), 32'(v));
      rd(OFS_PC, 32'(pc_m));
    end
    rd(fa(FA_STATUS), 32'h1f);
    // Literal operations with random zero flag beforehand
    for (int i = 0; i < 8; i++) begin
      {w_m, s} = {8'($urandom), 5'h03, 1'($urandom), 2'b00};
      k = (i > 3) ? w_m : 8'($urandom);
      case (lits[i % 4])
        OP_AND_LIT: v = w_m & k;
        OP_OR_LIT:  v = w_m | k;
        OP_XOR_LIT: v = w_m ^ k;
        default:    v = k;
      endcase
      wr(OFS_WORK, 32'(w_m));
      wr(fa(FA_STATUS), 32'(s));
      if (lits[i % 4] != OP_MOVE_LIT) s[SB_Z] = (v == 8'h00);
      exec({lits[i % 4], k}, 4);
      rd(OFS_WORK, 32'(v));
      rd(fa(FA_STATUS), 32'(s));
    end
    // Fixed words: standby, watchdog clear, option load
    wr(OFS_EVENTS, 32'h7);
    wr(fa(FA_STATUS), 32'h18);
    pul_m = 3'h4;
    exec(12'h003, 4);
    pul_m = 3'h2;
    rd(fa(FA_STATUS), 32'h10);
    exec(12'h004, 4);
    pul_m = 3'h0;
    rd(fa(FA_STATUS), 32'h18);
    rd(OFS_EVENTS, 32'h3);
    for (int i = 0; i < 2; i++) begin
      w_m = 8'($urandom) & 8'hf7;
      w_m[OPT_PSA] = 1'(i);
      opt_m = w_m;
      wr(OFS_WORK, 32'(w_m));
      exec(12'h002, 4);
      wr(OFS_EVENTS, 32'h7);
      exec({2'b00, CL_COM, 1'b1, FA_TIMER}, 4);
      exec({2'b00, CL_INC, 1'b0, FA_TIMER}, 4);
      rd(OFS_EVENTS, 32'h0);
      pul_m = {2'b00, i == 0};
      exec({OP_BIT_SET, 3'h2, FA_TIMER}, 4);
      pul_m = 3'h0;
      rd(OFS_EVENTS, i ? 32'h0 : 32'h4);
    end
    // Direction load, unlisted words, clear of the working register
    w_m = 8'($urandom);
    dir_m = w_m;
    wr(OFS_WORK, 32'(w_m));
    exec(12'h006, 4);
    rd(OFS_DIR, 32'(dir_m));
    wr(fa(FA_STATUS), 32'h1b);
    foreach (nops[i]) exec(nops[i], 4);
    rd(OFS_WORK, 32'(w_m));
    rd(fa(FA_STATUS), 32'h1b);
    exec(12'h040, 4);
    rd(OFS_WORK, 32'h0);
    rd(fa(FA_STATUS), 32'h1f);
    // Port writes use the pin levels, not the latch
    w_m = ~pin_in;
    out_m = w_m;
    wr(OFS_WORK, 32'(w_m));
    exec({7'h01, FA_PORT}, 4);
    out_m = pin_in;
    exec({2'b00, CL_MOV, 1'b1, FA_PORT}, 4);
    rd(fa(FA_PORT), 32'(pin_in));
    // Call, return and branch; bit 8 handling
    k = 8'($urandom);
    wr(OFS_PC, 32'h2f0);
    pc_m = 11'h2f0;
    wr(fa(FA_STATUS), 32'h78);
    exec({OP_CALL, k}, 8);
    pc_m = {2'b11, 1'b0, k};
    rd(OFS_PC, 32'(pc_m));
    v = ~k;
    exec({OP_RET_LIT, v}, 8);
    pc_m = 11'h2f1;
    rd(OFS_PC, 32'(pc_m));
    rd(OFS_WORK, 32'(v));
    wr(fa(FA_STATUS), 32'h18);
    wr(OFS_PC, 32'h0);
    exec({3'b101, 1'b1, k}, 8);
    rd(OFS_PC, 32'({1'b1, k}));
    // Write with no byte lanes selected is dropped
    sel <= 4'h0;
    wr(OFS_WORK, 32'h5a);
    sel <= 4'hf;
    rd(OFS_WORK, 32'(v));
    complete_run();
  end

endmodule // tb_top
